// ==== testbench/svr_link_master.sv ====
// behavioural serial link master that drives link clock and data toward the block
`timescale 1ns/1ps
module svr_link_master (
  input  wire logic i_c_lvl,
  input  wire logic i_d_lvl,
  output logic      o_link_clk,
  output logic      o_data
);
  logic clk_r;
  logic dat_r;
  logic busy = 1'b0;

  // strapped levels show between frames, so the link clock stands still there
  assign o_link_clk = busy ? clk_r : i_c_lvl;
  assign o_data     = busy ? dat_r : i_d_lvl;

  // last n bits of w, msb first, data changed while the clock is low
  task automatic send(input logic [8:0] w, input int n);
    // clock low before taking the pins, so no stray edge leaks at frame start
    clk_r = 1'b0;
    dat_r = w[n - 1];
    busy  = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      clk_r = 1'b0;
      dat_r = w[i];
      #6;
      clk_r = 1'b1;
      #6;
    end
    #6;
    busy = 1'b0;
  endtask : send
endmodule : svr_link_master

// ==== testbench/test_serial_voltage_id_reference.sv ====
// self-checking bench of the serial voltage reference block
`timescale 1ns/1ps
`include "svr_regs.svh"
module test_serial_voltage_id_reference;
  logic        clk, srst, link_clk, sdat, fix_sel, mode_sel, c_lvl, d_lvl;
  logic        psel, penable, pwrite, pready, pslverr, pgood;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0]  core_ref, bridge_ref, lc, lb, lvl, cd, ec, eb;
  logic [6:0]  start_lvl [4];
  logic [6:0]  fix_lvl [4];
  logic [1:0]  k;
  logic [32:0] exp_q [$];
  int          fails, tests_run, seed;

  svr_reference i_dut (.i_clk(clk), .i_srst(srst), .i_link_clk(link_clk), .i_serial_voltage_data(sdat),
    .i_fixed_target_select(fix_sel), .i_mode_select_pin(mode_sel), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_core_ref(core_ref), .o_bridge_ref(bridge_ref), .o_planes_power_good(pgood));
  svr_link_master i_link (.i_c_lvl(c_lvl), .i_d_lvl(d_lvl), .o_link_clk(link_clk), .o_data(sdat));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // one apb transfer, entered just after a rising edge; reads leave a note
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      exp_q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: no pready", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // wait for both references to land, then check them and power good
  task automatic settle(input logic [6:0] c, input logic [6:0] b, input logic pg);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 400 && !(core_ref === c && bridge_ref === b); i++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    chk({core_ref, bridge_ref, pg ? pgood : ~pgood}, {c, b, 1'b1});
  endtask : settle

  // read results are matched with the oldest note when pready shows them
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front());
  end

  // references may only move one code per step, never jump
  always @(posedge clk) begin
    if (!srst && (core_ref !== lc || bridge_ref !== lb))
      chk({7'(core_ref - lc + 7'h01) <= 7'h02, 7'(bridge_ref - lb + 7'h01) <= 7'h02}, 2'b11);
    lc <= core_ref;
    lb <= bridge_ref;
  end

  initial begin
    #(40 * 40000);
    fails++;
    test_done;
  end

  initial begin
    {srst, seed, fails, tests_run} = {1'b1, 32'd98044, 64'd0};
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fix_sel, mode_sel, c_lvl, d_lvl} = '0;
    start_lvl = '{`SVR_CODE_1V1, `SVR_CODE_1V0, `SVR_CODE_0V9, `SVR_CODE_0V8};
    fix_lvl = '{`SVR_CODE_1V4, `SVR_CODE_1V2, `SVR_CODE_1V0, `SVR_CODE_0V8};
    // link domain needs a few link edges to take reset while srst is still high
    i_link.send(9'h000, 4);
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `SVR_OFS_STATUS, 0, 33'h0_0000_7C7C);
    apb(1'b0, 8'h10, 0, 33'h1_0000_0000);
    apb(1'b1, `SVR_OFS_TICK, 0, 0);
    apb(1'b0, `SVR_OFS_TICK, 0, 0);
    // start-up and strapped codes, every level pair
    for (int m = 0; m < 8; m++) begin
      fix_sel <= m[2];
      {c_lvl, d_lvl} <= m[1:0];
      k = ~m[1:0];
      lvl = m[2] ? fix_lvl[m[1:0]] : start_lvl[m[1:0]];
      repeat (4) @(posedge clk);
      apb(1'b1, `SVR_OFS_CTRL, 1, 0);
      settle(lvl, lvl, 1'b1);
      if (m[2]) begin
        {c_lvl, d_lvl} <= k;
        settle(fix_lvl[k], fix_lvl[k], 1'b1);
      end
      apb(1'b1, `SVR_OFS_CTRL, 0, 0);
      // power good drops on the edge the task returns at; look one edge later
      @(posedge clk);
      chk(pgood, 1'b0);
      settle(`SVR_CODE_OFF, `SVR_CODE_OFF, 1'b0);
    end
    // parallel mode latched at enable stays off here
    {fix_sel, mode_sel} <= 2'b01;
    repeat (4) @(posedge clk);
    apb(1'b1, `SVR_OFS_CTRL, 1, 0);
    settle(`SVR_CODE_OFF, `SVR_CODE_OFF, 1'b0);
    apb(1'b1, `SVR_OFS_CTRL, 0, 0);
    // serial mode: start at 1.0 V, then host takes over after power good
    {mode_sel, c_lvl, d_lvl} <= 3'b001;
    repeat (4) @(posedge clk);
    apb(1'b1, `SVR_OFS_CTRL, 1, 0);
    settle(`SVR_CODE_1V0, `SVR_CODE_1V0, 1'b1);
    apb(1'b1, `SVR_OFS_CTRL, 3, 0);
    i_link.send(9'h000, 2);
    {ec, eb} = {`SVR_CODE_1V0, `SVR_CODE_1V0};
    for (int s = 1; s < 7; s++) begin
      cd = 7'($random(seed)) & 7'h3F;
      ec = s[1] ? cd : ec;
      eb = s[0] ? cd : eb;
      i_link.send({s[1:0], cd}, 9);
      settle(ec, eb, 1'b1);
    end
    // core plane off while bridge plane stays up
    i_link.send({2'b10, `SVR_CODE_OFF}, 9);
    settle(`SVR_CODE_OFF, eb, 1'b1);
    apb(1'b1, `SVR_OFS_CTRL, 1, 0);
    i_link.send(9'h180, 9);
    settle(`SVR_CODE_1V0, `SVR_CODE_1V0, 1'b1);
    apb(1'b1, `SVR_OFS_CTRL, 3, 0);
    i_link.send(9'h000, 2);
    settle(`SVR_CODE_1V0, `SVR_CODE_1V0, 1'b1);
    i_link.send(9'h1B0, 9);
    settle(7'h30, 7'h30, 1'b1);
    apb(1'b1, `SVR_OFS_CTRL, 7, 0);
    @(posedge clk);
    chk(pgood, 1'b0);
    settle(`SVR_CODE_OFF, `SVR_CODE_OFF, 1'b0);
    test_done;
  end
endmodule : test_serial_voltage_id_reference

// ==== verilog/svr_pkg.sv ====
// types and helper functions of the serial voltage reference block
package svr_pkg;
  `include "svr_regs.svh"
  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_SOFT = 2'b01,
    ST_RUN  = 2'b10,
    ST_DOWN = 2'b11
  } svr_state_t;

  // one set-voltage command as shifted in on the link
  typedef struct packed {
    logic       core_sel;
    logic       bridge_sel;
    logic [6:0] code;
  } svr_cmd_t;

  // main-domain state
  typedef struct packed {
    svr_state_t st;
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic       tog_s3;
    logic       en_d;
    logic       ctrl_en;
    logic       ctrl_pok;
    logic       ctrl_fault;
    logic [15:0] tick_per;
    logic [15:0] tick_cnt;
    logic       mode_par;
    logic [6:0] hold;
    logic [6:0] core_ref;
    logic [6:0] bridge_ref;
    logic [6:0] core_tgt;
    logic [6:0] bridge_tgt;
    logic       pgood;
    logic       arm;
    logic [31:0] prdata;
    logic       pready;
    logic       pslverr;
  } svr_main_t;

  // link-domain state
  typedef struct packed {
    logic       rst_s1;
    logic       rst_s2;
    logic       arm_s1;
    logic       arm_s2;
    logic [3:0] cnt;
    logic [7:0] sh;
    svr_cmd_t   word;
    logic       tog;
  } svr_link_t;

  // one code step toward the target
  function automatic logic [6:0] svr_step(input logic [6:0] cur, input logic [6:0] tgt);
    if (cur < tgt)
      return cur + 7'h01;
    else if (cur > tgt)
      return cur - 7'h01;
    return cur;
  endfunction : svr_step

  // start-up code from clock/data levels
  function automatic logic [6:0] svr_start_code(input logic c, input logic d);
    case ({c, d})
      2'b00:   return `SVR_CODE_1V1;
      2'b01:   return `SVR_CODE_1V0;
      2'b10:   return `SVR_CODE_0V9;
      default: return `SVR_CODE_0V8;
    endcase
  endfunction : svr_start_code

  // jumper-fixed code from clock/data levels
  function automatic logic [6:0] svr_fixed_code(input logic c, input logic d);
    case ({c, d})
      2'b00:   return `SVR_CODE_1V4;
      2'b01:   return `SVR_CODE_1V2;
      2'b10:   return `SVR_CODE_1V0;
      default: return `SVR_CODE_0V8;
    endcase
  endfunction : svr_fixed_code
endpackage : svr_pkg

// ==== verilog/svr_reference.sv ====
// serial voltage-id reference controller with apb registers and link receiver
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "svr_regs.svh"
module svr_reference import svr_pkg::*; (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_link_clk,
  input  wire logic        i_serial_voltage_data,
  input  wire logic        i_fixed_target_select,
  input  wire logic        i_mode_select_pin,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [6:0]       o_core_ref,
  output logic [6:0]       o_bridge_ref,
  output logic             o_planes_power_good
);

  localparam logic [15:0] TICK_RESET = 16'(`SVR_STEP_CYCLES - 1);

  svr_main_t r;
  svr_main_t n;
  svr_link_t l;
  svr_link_t ln;

  logic       s_link_clk;
  logic       s_data;
  logic       s_fixed;
  logic       s_mode;
  logic       cmd_evt;
  logic       tick;
  logic       en_rise;
  logic       both_at;
  logic       wr_en;
  logic [6:0] fix_code;

  // synchronised pin levels, second stage only
  assign s_link_clk = r.pin_s2[4];
  assign s_data     = r.pin_s2[3];
  assign s_fixed    = r.pin_s2[2];
  assign s_mode     = r.pin_s2[1];
  assign cmd_evt    = r.pin_s2[0] ^ r.tog_s3;
  // compare with >= so a shorter period written mid-count cannot stall the ramp for a full wrap
  assign tick       = (r.tick_cnt >= r.tick_per);
  assign en_rise    = r.ctrl_en & ~r.en_d;
  assign both_at    = (r.core_ref == r.core_tgt) && (r.bridge_ref == r.bridge_tgt);
  assign wr_en      = i_psel & i_penable & r.pready & i_pwrite;
  assign fix_code   = svr_fixed_code(s_link_clk, s_data);

  // main-domain next state
  always_comb begin
    n = r;
    n.pin_s1 = {i_link_clk, i_serial_voltage_data, i_fixed_target_select, i_mode_select_pin, l.tog};
    n.pin_s2 = r.pin_s1;
    n.tog_s3 = r.pin_s2[0];
    n.en_d   = r.ctrl_en;
    // tick divider sets the stair-step rate
    n.tick_cnt = tick ? 16'h0000 : r.tick_cnt + 16'h0001; // RULE19

    unique case (r.st)
      ST_OFF: begin
        if (en_rise) begin
          n.mode_par = s_mode; // RULE18
          n.hold = svr_start_code(s_link_clk, s_data); // RULE1 RULE2 RULE3
          if (!s_mode) begin
            n.core_tgt   = s_fixed ? fix_code : svr_start_code(s_link_clk, s_data); // RULE7
            n.bridge_tgt = s_fixed ? fix_code : svr_start_code(s_link_clk, s_data);
            n.tick_cnt   = 16'h0000;
            n.st         = ST_SOFT;
          end
        end
      end
      ST_SOFT: begin
        if (!r.ctrl_en || r.ctrl_fault) begin
          n.st = ST_DOWN;
        end else begin
          // fixed straps may move while ramping; keep following them
          if (s_fixed) begin
            n.core_tgt   = fix_code; // RULE8 RULE9
            n.bridge_tgt = fix_code;
          end else begin
            n.core_tgt   = r.hold;
            n.bridge_tgt = r.hold;
          end
          if (both_at && r.core_tgt == n.core_tgt) begin
            n.st    = ST_RUN;
            n.pgood = 1'b1; // RULE5 RULE9
          end
        end
      end
      ST_RUN: begin
        if (!r.ctrl_en || r.ctrl_fault) begin
          n.pgood = 1'b0; // RULE6 RULE16
          n.st    = ST_DOWN;
        end else if (s_fixed) begin
          n.core_tgt   = fix_code; // RULE8
          n.bridge_tgt = fix_code;
        end else if (!r.ctrl_pok) begin
          // link is disarmed here, so commands cannot slip in
          n.core_tgt   = r.hold; // RULE14
          n.bridge_tgt = r.hold;
        end else if (cmd_evt) begin
          // on power ok return the targets stay until this fires
          if (l.word.core_sel)
            n.core_tgt = l.word.code; // RULE11 RULE12 RULE15 RULE17
          if (l.word.bridge_sel)
            n.bridge_tgt = l.word.code; // RULE12
        end
        // core code may reach off; power good is left alone
        n.pgood = n.st == ST_RUN; // RULE13
      end
      ST_DOWN: begin
        n.pgood = 1'b0;
        if (both_at && r.core_tgt == `SVR_CODE_OFF && r.bridge_tgt == `SVR_CODE_OFF)
          n.st = ST_OFF;
      end
    endcase
    if (n.st == ST_DOWN) begin
      n.core_tgt   = `SVR_CODE_OFF; // RULE6 RULE16
      n.bridge_tgt = `SVR_CODE_OFF;
    end

    // one code step per tick, never a jump
    if (tick && r.st != ST_OFF) begin
      n.core_ref   = svr_step(r.core_ref, r.core_tgt); // RULE4 RULE19
      n.bridge_ref = svr_step(r.bridge_ref, r.bridge_tgt);
    end

    // link accepts frames only after host power ok in normal operation
    n.arm = (n.st == ST_RUN) && r.ctrl_pok && !s_fixed && !r.mode_par; // RULE10 RULE14

    // apb: answer in the first access cycle, data formed in setup
    n.pready  = i_psel & ~i_penable;
    n.pslverr = 1'b0;
    n.prdata  = 32'h0000_0000;
    if (i_psel && !i_penable) begin
      unique case (i_paddr)
        `SVR_OFS_CTRL:   n.prdata = {29'h0, r.ctrl_fault, r.ctrl_pok, r.ctrl_en};
        `SVR_OFS_TICK:   n.prdata = {16'h0000, r.tick_per};
        `SVR_OFS_STATUS: n.prdata = {11'h0, s_fixed, r.st, r.mode_par, r.pgood, 1'b0,
                                     r.bridge_ref, 1'b0, r.core_ref};
        `SVR_OFS_TARGET: n.prdata = {9'h0, r.bridge_tgt, 1'b0, r.core_tgt, 1'b0, r.hold};
        default:         n.pslverr = 1'b1;
      endcase
    end
    if (wr_en) begin
      if (i_paddr == `SVR_OFS_CTRL) begin
        n.ctrl_en    = i_pwdata[`SVR_CTRL_EN];
        n.ctrl_pok   = i_pwdata[`SVR_CTRL_POK];
        n.ctrl_fault = i_pwdata[`SVR_CTRL_FAULT];
      end
      if (i_paddr == `SVR_OFS_TICK)
        n.tick_per = i_pwdata[15:0];
    end

    if (i_srst) begin
      n            = '0;
      n.st         = ST_OFF;
      n.tick_per   = TICK_RESET;
      n.hold       = `SVR_CODE_OFF;
      n.core_ref   = `SVR_CODE_OFF;
      n.bridge_ref = `SVR_CODE_OFF;
      n.core_tgt   = `SVR_CODE_OFF;
      n.bridge_tgt = `SVR_CODE_OFF;
    end
  end

  // main-domain registers
  always_ff @(posedge i_clk) begin
    r <= n;
  end

  // link receiver: nine bits msb first, core select, bridge select, code
  always_comb begin
    ln = l;
    ln.rst_s1 = i_srst;
    ln.rst_s2 = l.rst_s1;
    ln.arm_s1 = r.arm;
    ln.arm_s2 = l.arm_s1;
    if (l.rst_s2 || !l.arm_s2) begin
      // ignoring the line while disarmed also realigns framing
      ln.cnt = 4'h0; // RULE14
    end else if (l.cnt == `SVR_LINK_BITS) begin
      ln.word = {l.sh, i_serial_voltage_data}; // RULE11
      ln.tog  = ~l.tog;
      ln.cnt  = 4'h0;
    end else begin
      ln.sh  = {l.sh[6:0], i_serial_voltage_data};
      ln.cnt = l.cnt + 4'h1;
    end
    if (l.rst_s2) begin
      ln.tog  = 1'b0;
      ln.word = '0;
      ln.sh   = 8'h00;
    end
  end

  // word is held for a full frame, so reading it after the toggle sync is safe
  always_ff @(posedge i_link_clk) begin
    l <= ln;
  end

  // outputs straight from flip-flops
  assign o_prdata            = r.prdata;
  assign o_pready            = r.pready;
  assign o_pslverr           = r.pslverr;
  assign o_core_ref          = r.core_ref;
  assign o_bridge_ref        = r.bridge_ref;
  assign o_planes_power_good = r.pgood;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_enable_rise;
    r.st == ST_OFF && en_rise && !s_mode;
  endsequence
  sequence s_run_ok;
    r.st == ST_RUN && r.ctrl_en && !r.ctrl_fault;
  endsequence
  sequence s_lose_power;
    r.st == ST_RUN && (!r.ctrl_en || r.ctrl_fault);
  endsequence

  a_startup_latch: assert property (s_enable_rise |=> // RULE3
    r.hold == svr_start_code($past(s_link_clk), $past(s_data)) && r.st == ST_SOFT)
    else $error("start-up code not latched at enable");
  a_mode_latch: assert property (r.st == ST_OFF && en_rise |=> r.mode_par == $past(s_mode)) // RULE18
    else $error("mode select not latched");
  a_soft_done: assert property (r.st == ST_SOFT && both_at && r.ctrl_en && !r.ctrl_fault // RULE5
    && r.core_tgt == n.core_tgt |=> r.pgood && r.st == ST_RUN)
    else $error("power good missing after soft-start");
  a_pgood_state: assert property (r.pgood |-> r.st == ST_RUN) // RULE9
    else $error("power good outside normal operation");
  a_enable_loss: assert property (s_lose_power |=> !r.pgood ##0 r.st == ST_DOWN // RULE6
    ##0 r.core_tgt == `SVR_CODE_OFF)
    else $error("no shutdown on enable loss");
  a_ref_step: assert property (1'b1 |=> (r.core_ref == $past(r.core_ref) // RULE4
    || r.core_ref == 7'($past(r.core_ref) + 7'h01) || r.core_ref == 7'($past(r.core_ref) - 7'h01)))
    else $error("core reference jumped");
  a_tick_hold: assert property (!tick && r.st != ST_OFF |=> r.bridge_ref == $past(r.bridge_ref)) // RULE19
    else $error("reference moved without tick");
  a_fixed_follow: assert property (s_run_ok and s_fixed |=> // RULE8
    r.core_tgt == svr_fixed_code($past(s_link_clk), $past(s_data)))
    else $error("fixed target not followed");
  a_pok_hold: assert property (s_run_ok and (!s_fixed && !r.ctrl_pok) |=> // RULE14
    r.core_tgt == r.hold && r.bridge_tgt == r.hold)
    else $error("targets not returned to held code");
  a_cmd_apply: assert property (s_run_ok and (!s_fixed && r.ctrl_pok && cmd_evt // RULE12
    && l.word.bridge_sel) |=> r.bridge_tgt == $past(l.word.code))
    else $error("bridge command not applied");
  a_core_off: assert property (s_run_ok |=> r.pgood [*1]) // RULE13
    else $error("power good dropped in normal operation");

endmodule : svr_reference

// ==== verilog/svr_regs.svh ====
// register offsets, field positions, reset values, voltage codes and timing counts
// What this block does
// (RULE1) with fixed-select low, start-up code comes from the two serial lines after reset
// (RULE2) start-up levels 00/01/10/11 give 1.1/1.0/0.9/0.8 V plane targets
// (RULE3) start-up code latched into holding register at enable rise, forwarded as target
// (RULE4) soft-start stair-steps both plane references to target, never one jump
// (RULE5) planes power good rises when soft-start ends
// (RULE6) losing enable drops power good and ramps both references toward zero
// (RULE7) fixed-select high maps 00/01/10/11 to 1.4/1.2/1.0/0.8 V
// (RULE8) fixed-mode inputs may change; the targets follow them
// (RULE9) fixed mode soft-starts both planes, power good only after soft-start ends
// (RULE10) host raises power ok only after power good is high
// (RULE11) with power ok, decode plane select and code from each command, step there
// (RULE12) a command may select core, bridge plane or both
// (RULE13) core plane turned off by command keeps power good asserted
// (RULE14) power ok low steps both planes to held start-up code, link ignored
// (RULE15) power ok high again keeps references until a new command
// (RULE16) power good loss in normal operation stair-steps both planes to near zero
// (RULE17) codes are seven bits, 1.55 V minus 12.5 mV per step
// (RULE18) mode-select pin sampled at enable rise: low serial, high parallel
// (RULE19) references move one code step per configurable tick period
`ifndef SVR_REGS_SVH
`define SVR_REGS_SVH
`define SVR_OFS_CTRL     8'h00
`define SVR_OFS_TICK     8'h04
`define SVR_OFS_STATUS   8'h08
`define SVR_OFS_TARGET   8'h0C
`define SVR_CTRL_EN      0
`define SVR_CTRL_POK     1
`define SVR_CTRL_FAULT   2
`define SVR_STEP_TIME_NS 1000
`define SVR_CLK_MHZ      25
`define SVR_STEP_CYCLES  ((`SVR_STEP_TIME_NS * `SVR_CLK_MHZ) / 1000)
`define SVR_CODE_OFF     7'h7C
`define SVR_CODE_1V55    7'h00
`define SVR_CODE_1V4     7'h0C
`define SVR_CODE_1V2     7'h1C
`define SVR_CODE_1V1     7'h24
`define SVR_CODE_1V0     7'h2C
`define SVR_CODE_0V9     7'h34
`define SVR_CODE_0V8     7'h3C
`define SVR_LINK_BITS    4'h8
`endif
